// >>> src/bg_map.svh
// Purpose: register offsets, field positions, reset values and timings of the gauge
// Assumes: 20 MHz system clock
// Notes: definitions only
`ifndef BG_MAP_SVH
`define BG_MAP_SVH

// ****************************************
// register byte addresses
// ****************************************
`define BG_OFS_CELL_VOLTAGE 8'h02
`define BG_OFS_CHARGE_LEVEL 8'h04
`define BG_OFS_SPECIAL_CMD 8'h06
`define BG_OFS_REVISION 8'h08
`define BG_OFS_SETUP 8'h0C
`define BG_OFS_SYSTEM_CMD 8'hFE

// ****************************************
// setup register fields and reset value
// ****************************************
`define BG_SETUP_RESET 16'h971C
`define BG_SETUP_COMP_MSB 15
`define BG_SETUP_COMP_LSB 8
`define BG_SETUP_SLEEP_BIT 7
`define BG_SETUP_ALERT_BIT 5
`define BG_SETUP_THR_MSB 4
`define BG_SETUP_THR_LSB 0
`define BG_THR_BASE_PCT 8'h20

// ****************************************
// command values
// ****************************************
`define BG_CMD_QUICK_START 16'h4000
`define BG_CMD_FULL_RESET 16'h0054

// ****************************************
// timing
// ****************************************
`define BG_CLK_PERIOD_NS 50
`define BG_FIRST_AVG_MS 125
`define BG_AVG_MS 500
`define BG_BUS_SLEEP_MS 2000
`define BG_MS_TO_CYC(ms) ((ms) * (1000000 / `BG_CLK_PERIOD_NS))

`endif

// >>> src/bg_pkg.sv
// Purpose: shared types of the gauge control block
// Assumes: nothing
// Notes: constants live in bg_map.svh
package bg_pkg;

  // ****************************************
  // serial slave states
  // ****************************************
  typedef enum logic [3:0] {
    BG_IDLE = 4'b0000,
    BG_ADDR = 4'b0001,
    BG_ADDR_ACK = 4'b0010,
    BG_PTR = 4'b0011,
    BG_PTR_ACK = 4'b0100,
    BG_WDATA = 4'b0101,
    BG_WACK = 4'b0110,
    BG_RLOAD = 4'b0111,
    BG_RDATA = 4'b1000,
    BG_RACK = 4'b1001
  } bg_i2c_st_t;

endpackage : bg_pkg

// >>> src/bg_gauge.sv
// Purpose: host-facing control of a battery gauge: serial slave, registers, alert, sleep
// Assumes: scl/sda/restart pin asynchronous to clk_i; model and converter outside
// Notes: sda is open-drain, driven low while sda_oe_o is high
`timescale 1ns/1ns
`include "bg_map.svh"

// Contract
// - quick-start on pin rise or 4000h write
// - quick-start restarts calculation like power-up
// - power-up: first conversion gives first estimate
// - alert when charge below threshold
// - alert drives pin low, sets flag
// - pin low until host clears flag
// - rearm only after rising above threshold (code rearms on any awake result at or above it)
// - alert active from power-up
// - sleep keeps pending alert
// - both bus lines low long enters sleep
// - bus sleep wakes on line rising edge
// - sleep halts, wake resumes without reinit
// - sleep bit sleeps until cleared
// - 0054h to system command resets all
// - reset at last bit, no acknowledge
// - only whole 16-bit words valid
// - short writes discarded
// - reserved addresses read undefined
// - cell voltage holds 12-bit result
// - average 125ms first, then 500ms
// - full 500ms period after wake
// - per-register read/write access
// - threshold two's complement, 32% to 1%
module bg_gauge
  import bg_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h36,
  parameter logic [15:0] REVISION = 16'h0001, // arbitrary value
  parameter int unsigned FIRST_AVG_CYC = `BG_MS_TO_CYC(`BG_FIRST_AVG_MS),
  parameter int unsigned AVG_CYC = `BG_MS_TO_CYC(`BG_AVG_MS),
  parameter int unsigned BUS_SLEEP_CYC = `BG_MS_TO_CYC(`BG_BUS_SLEEP_MS)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // pins
  input wire logic restart_pin_i,
  output logic low_charge_alert_n_o,
  // converter and model
  input wire logic [11:0] adc_avg_i,
  input wire logic [15:0] soc_new_i,
  input wire logic soc_valid_i,
  output logic gauge_run_o,
  output logic gauge_restart_o,
  output logic first_estimate_o
);

  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic soft_rst_reg;
  logic rst;
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic [2:0] qs_sync_reg;
  logic scl_f_reg, sda_f_reg, qs_f_reg;
  logic scl_q_reg, sda_q_reg, qs_q_reg;
  logic scl_rise, scl_fall, sda_rise, start_ev, stop_ev, qs_pin_rise;

  assign rst = ~rst_n_i | soft_rst_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      qs_sync_reg <= 3'h0;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      qs_f_reg <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      qs_q_reg <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      qs_sync_reg <= {qs_sync_reg[1:0], restart_pin_i};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_f_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_f_reg <= sda_sync_reg[2];
      end
      if (qs_sync_reg[1] == qs_sync_reg[2]) begin
        qs_f_reg <= qs_sync_reg[2];
      end
      scl_q_reg <= scl_f_reg;
      sda_q_reg <= sda_f_reg;
      qs_q_reg <= qs_f_reg;
    end
  end

  assign scl_rise = scl_f_reg & ~scl_q_reg;
  // fall taken as the filter settles: ack and data move before the next scl rise
  assign scl_fall = scl_f_reg & (scl_sync_reg[1] == scl_sync_reg[2]) & ~scl_sync_reg[2];
  assign sda_rise = sda_f_reg & ~sda_q_reg;
  assign start_ev = scl_f_reg & scl_q_reg & ~sda_f_reg & sda_q_reg;
  assign stop_ev = scl_f_reg & scl_q_reg & sda_f_reg & ~sda_q_reg;
  assign qs_pin_rise = qs_f_reg & ~qs_q_reg;

  // ****************************************
  // register state
  // ****************************************
  logic [11:0] cell_voltage_reg;
  logic [15:0] charge_level_reg;
  logic [7:0] comp_reg;
  logic sleep_bit_reg;
  logic alert_flag_reg;
  logic [4:0] alert_threshold_reg;
  logic [15:0] setup_view;
  logic [7:0] ptr_reg;
  logic [15:0] rd_mux;

  assign setup_view = {comp_reg, sleep_bit_reg, 1'b0, alert_flag_reg, alert_threshold_reg};

  always_comb begin
    unique case (ptr_reg)
      `BG_OFS_CELL_VOLTAGE: rd_mux = {cell_voltage_reg, 4'h0};
      `BG_OFS_CHARGE_LEVEL: rd_mux = charge_level_reg;
      `BG_OFS_REVISION: rd_mux = REVISION;
      `BG_OFS_SETUP: rd_mux = setup_view;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ****************************************
  // serial slave
  // ****************************************
  bg_i2c_st_t st_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] hi_byte_reg;
  logic [7:0] rd_lo_reg;
  logic byte_sel_reg;
  logic rw_reg;
  logic sda_oe_reg;
  logic wr_stb_reg;
  logic [7:0] wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic [7:0] byte_now;
  logic full_reset_hit;

  assign byte_now = {shift_reg[6:0], sda_f_reg};
  assign full_reset_hit = (st_reg == BG_WDATA) && scl_rise && (bit_cnt_reg == 4'h7) &&
                          byte_sel_reg && (ptr_reg == `BG_OFS_SYSTEM_CMD) &&
                          ({hi_byte_reg, byte_now} == `BG_CMD_FULL_RESET);

  // full reset fires on the last data bit, before any acknowledge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= full_reset_hit;
    end
  end

  always_ff @(posedge clk_i) begin
    wr_stb_reg <= 1'b0;
    if (rst) begin
      st_reg <= BG_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      hi_byte_reg <= 8'h00;
      rd_lo_reg <= 8'h00;
      byte_sel_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 16'h0000;
    end else if (start_ev) begin
      st_reg <= BG_ADDR;
      bit_cnt_reg <= 4'h0;
      byte_sel_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      st_reg <= BG_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        BG_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        BG_ADDR, BG_PTR, BG_WDATA: begin
          if (scl_rise) begin
            shift_reg <= byte_now;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b1;
            if (st_reg == BG_ADDR) begin
              if (shift_reg[7:1] == SLAVE_ADDR) begin
                rw_reg <= shift_reg[0];
                st_reg <= BG_ADDR_ACK;
              end else begin
                sda_oe_reg <= 1'b0;
                st_reg <= BG_IDLE;
              end
            end else if (st_reg == BG_PTR) begin
              ptr_reg <= shift_reg;
              byte_sel_reg <= 1'b0;
              st_reg <= BG_PTR_ACK;
            end else if (!byte_sel_reg) begin
              hi_byte_reg <= shift_reg;
              byte_sel_reg <= 1'b1;
              st_reg <= BG_WACK;
            end else begin
              wr_stb_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= {hi_byte_reg, shift_reg};
              ptr_reg <= ptr_reg + 8'h02;
              byte_sel_reg <= 1'b0;
              st_reg <= BG_WACK;
            end
          end
        end
        BG_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            st_reg <= rw_reg ? BG_RLOAD : BG_PTR;
          end
        end
        BG_PTR_ACK, BG_WACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            st_reg <= BG_WDATA;
          end
        end
        BG_RLOAD: begin
          tx_reg <= rd_mux[15:8];
          rd_lo_reg <= rd_mux[7:0];
          sda_oe_reg <= ~rd_mux[15];
          bit_cnt_reg <= 4'h0;
          st_reg <= BG_RDATA;
        end
        BG_RDATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              st_reg <= BG_RACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        BG_RACK: begin
          if (scl_rise && sda_f_reg) begin
            st_reg <= BG_IDLE;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (!byte_sel_reg) begin
              byte_sel_reg <= 1'b1;
              tx_reg <= rd_lo_reg;
              sda_oe_reg <= ~rd_lo_reg[7];
              st_reg <= BG_RDATA;
            end else begin
              byte_sel_reg <= 1'b0;
              ptr_reg <= ptr_reg + 8'h02;
              st_reg <= BG_RLOAD;
            end
          end
        end
        default: begin
          st_reg <= BG_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // sleep control
  // ****************************************
  logic [25:0] idle_cnt_reg;
  logic bus_sleep_reg;
  logic asleep;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      idle_cnt_reg <= 26'h0000000;
      bus_sleep_reg <= 1'b0;
    end else if (bus_sleep_reg) begin
      idle_cnt_reg <= 26'h0000000;
      if (scl_rise || sda_rise) begin
        bus_sleep_reg <= 1'b0;
      end
    end else if (!scl_f_reg && !sda_f_reg) begin
      if (idle_cnt_reg >= 26'(BUS_SLEEP_CYC - 1)) begin
        bus_sleep_reg <= 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 26'h0000001;
      end
    end else begin
      idle_cnt_reg <= 26'h0000000;
    end
  end

  assign asleep = bus_sleep_reg | sleep_bit_reg;

  // ****************************************
  // software-written registers and commands
  // ****************************************
  logic qs_cmd_reg;
  logic alert_set;
  logic setup_wr;

  assign setup_wr = wr_stb_reg && (wr_addr_reg == `BG_OFS_SETUP);

  always_ff @(posedge clk_i) begin
    if (rst) begin
      comp_reg <= 8'(`BG_SETUP_RESET >> `BG_SETUP_COMP_LSB);
      sleep_bit_reg <= 1'(`BG_SETUP_RESET >> `BG_SETUP_SLEEP_BIT);
      alert_threshold_reg <= 5'(`BG_SETUP_RESET >> `BG_SETUP_THR_LSB);
    end else if (setup_wr) begin
      comp_reg <= wr_data_reg[`BG_SETUP_COMP_MSB:`BG_SETUP_COMP_LSB];
      sleep_bit_reg <= wr_data_reg[`BG_SETUP_SLEEP_BIT];
      alert_threshold_reg <= wr_data_reg[`BG_SETUP_THR_MSB:`BG_SETUP_THR_LSB];
    end
  end

  // quick-start command; other special values are ignored
  always_ff @(posedge clk_i) begin
    if (rst) begin
      qs_cmd_reg <= 1'b0;
    end else begin
      qs_cmd_reg <= wr_stb_reg && (wr_addr_reg == `BG_OFS_SPECIAL_CMD) &&
                    (wr_data_reg == `BG_CMD_QUICK_START);
    end
  end

  // ****************************************
  // conversion timing and model hand-off
  // ****************************************
  logic [25:0] conv_cnt_reg;
  logic first_reg;
  logic restart_now;
  logic conv_done;

  assign restart_now = qs_cmd_reg | qs_pin_rise;
  assign conv_done = !asleep && (conv_cnt_reg == 26'h0000000);

  always_ff @(posedge clk_i) begin
    if (rst || restart_now) begin
      conv_cnt_reg <= 26'(FIRST_AVG_CYC - 1);
      first_reg <= 1'b1;
      cell_voltage_reg <= 12'h000;
    end else if (asleep) begin
      conv_cnt_reg <= 26'(AVG_CYC - 1);
    end else if (conv_done) begin
      conv_cnt_reg <= 26'(AVG_CYC - 1);
      first_reg <= 1'b0;
      cell_voltage_reg <= adc_avg_i;
    end else begin
      conv_cnt_reg <= conv_cnt_reg - 26'h0000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      gauge_restart_o <= 1'b1;
      first_estimate_o <= 1'b0;
      gauge_run_o <= 1'b0;
    end else begin
      gauge_restart_o <= restart_now;
      first_estimate_o <= conv_done && first_reg;
      gauge_run_o <= ~asleep;
    end
  end

  // model results are taken only while awake; state is kept across sleep
  always_ff @(posedge clk_i) begin
    if (rst || restart_now) begin
      charge_level_reg <= 16'h0000;
    end else if (soc_valid_i && !asleep) begin
      charge_level_reg <= soc_new_i;
    end
  end

  // ****************************************
  // low-charge alert
  // ****************************************
  logic armed_reg;
  logic [7:0] thr_pct;
  logic below;

  assign thr_pct = `BG_THR_BASE_PCT - {3'h0, alert_threshold_reg};
  assign below = soc_new_i[15:8] < thr_pct;
  assign alert_set = soc_valid_i && !asleep && below && armed_reg;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      armed_reg <= 1'b1;
    end else if (soc_valid_i && !asleep) begin
      if (alert_set) begin
        armed_reg <= 1'b0;
      end else if (!below) begin
        armed_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      alert_flag_reg <= 1'b0;
    end else if (alert_set) begin
      alert_flag_reg <= 1'b1;
    end else if (setup_wr) begin
      alert_flag_reg <= alert_flag_reg & wr_data_reg[`BG_SETUP_ALERT_BIT];
    end
  end

  // pin follows the flag only; sleep does not touch it
  always_ff @(posedge clk_i) begin
    if (rst) begin
      low_charge_alert_n_o <= 1'b1;
    end else begin
      low_charge_alert_n_o <= ~alert_flag_reg;
    end
  end

  // ****************************************
  // bus pin drivers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= sda_oe_reg;
    end
  end

endmodule : bg_gauge

// >>> verif/bg_gauge_chk.sv
// Purpose: port checks of the gauge control block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to bg_gauge at the foot
`timescale 1ns/1ns
module bg_gauge_chk #(
  parameter int unsigned FIRST_AVG_CYC = 50,
  parameter int unsigned BUS_SLEEP_CYC = 100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic restart_pin_i,
  input wire logic low_charge_alert_n_o,
  // model side
  input wire logic [15:0] soc_new_i,
  input wire logic soc_valid_i,
  input wire logic gauge_run_o,
  input wire logic gauge_restart_o,
  input wire logic first_estimate_o
);
  logic scl_q, sda_q, est_seen;
  logic [7:0] quiet;
  logic [7:0] pct;
  int unsigned run_cnt, low_cnt;
  assign pct = soc_new_i[15:8];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // bus activity counters
  // ****************************************
  always_ff @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (!rst_n_i || scl_i != scl_q || sda_i != sda_q) quiet <= 8'h00;
    else if (quiet != 8'hFF) quiet <= quiet + 8'h01;
    if (!rst_n_i || scl_i || sda_i) low_cnt <= 0;
    else if (low_cnt < BUS_SLEEP_CYC + 20) low_cnt <= low_cnt + 1;
  end
  // ****************************************
  // run time since restart
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || gauge_restart_o) run_cnt <= 0;
    else if (gauge_run_o) run_cnt <= run_cnt + 1;
    if (!rst_n_i || gauge_restart_o) est_seen <= 1'b0;
    else if (first_estimate_o) est_seen <= 1'b1;
  end
  AST_QS_PIN: assert property (
    $rose(restart_pin_i) && gauge_run_o |-> ##[1:6] gauge_restart_o)
    else $error("quick-start pin edge not acted on");
  AST_RESTART_ONE: assert property (
    gauge_restart_o |=> !gauge_restart_o)
    else $error("restart pulse longer than one cycle");
  AST_FIRST_EST: assert property (
    first_estimate_o |-> !est_seen && run_cnt + 3 >= FIRST_AVG_CYC
      && run_cnt <= FIRST_AVG_CYC + 3)
    else $error("first estimate at wrong time");
  AST_ALERT_CAUSE: assert property (
    $fell(low_charge_alert_n_o) |-> $past(soc_valid_i, 2) && $past(pct, 2) < 8'h20)
    else $error("alert without low charge result");
  AST_ALERT_RELEASE: assert property (
    $rose(low_charge_alert_n_o) |-> quiet < 8'h18)
    else $error("alert released without bus write");
  AST_SLEEP_ALERT: assert property (
    !gauge_run_o && !$past(gauge_run_o) && quiet > 8'h18 |-> $stable(low_charge_alert_n_o))
    else $error("alert changed in sleep");
  AST_BUS_SLEEP: assert property (
    low_cnt == BUS_SLEEP_CYC + 8 |-> !gauge_run_o)
    else $error("no sleep after long bus low");
  AST_BUS_WAKE: assert property (
    $rose(scl_i) && low_cnt > BUS_SLEEP_CYC + 8 |-> ##[1:8] gauge_run_o)
    else $error("no wake on bus edge");
  AST_SLEEP_HALT: assert property (
    !gauge_run_o |-> !first_estimate_o)
    else $error("gauge work during sleep");
endmodule : bg_gauge_chk

bind bg_gauge bg_gauge_chk #(
  .FIRST_AVG_CYC(FIRST_AVG_CYC),
  .BUS_SLEEP_CYC(BUS_SLEEP_CYC)
) i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .restart_pin_i(restart_pin_i), .low_charge_alert_n_o(low_charge_alert_n_o),
  .soc_new_i(soc_new_i), .soc_valid_i(soc_valid_i), .gauge_run_o(gauge_run_o),
  .gauge_restart_o(gauge_restart_o), .first_estimate_o(first_estimate_o)
);

// >>> verif/bg_host_model.sv
// Purpose: bus master host for the gauge bench
// Assumes: sda_i is the resolved wire with pull-up
// Notes: tasks start on a falling clock edge; bit period 8 ticks
`timescale 1ns/1ns
module bg_host_model (
  // bus lines
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  localparam logic [6:0] DEV = 7'h36;
  int t = 50;
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic bit_x(input logic b, output logic r);
    #(2 * t);
    sda_pull_o = ~b;
    #(3 * t);
    scl_o = 1'b1;
    #(3 * t);
    r = sda_i;
    scl_o = 1'b0;
  endtask : bit_x
  task automatic start();
    if (!scl_o) begin
      #(2 * t);
      sda_pull_o = 1'b0;
      #(3 * t);
      scl_o = 1'b1;
      #(3 * t);
    end
    sda_pull_o = 1'b1;
    #(4 * t);
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #(2 * t);
    sda_pull_o = 1'b1;
    #(3 * t);
    scl_o = 1'b1;
    #(3 * t);
    sda_pull_o = 1'b0;
    #(4 * t);
  endtask : stop
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] r,
                        output logic a);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(last, a);
  endtask : byte_x
  // whole words only, unless a short write is asked for
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int nb,
                    output logic ok);
    logic [7:0] r;
    logic a;
    start();
    byte_x({DEV, 1'b0}, 1'b1, r, a);
    byte_x(p, 1'b1, r, a);
    if (nb > 0) byte_x(d[15:8], 1'b1, r, a);
    if (nb > 1) byte_x(d[7:0], 1'b1, r, a);
    ok = ~a;
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [7:0] r;
    logic a;
    start();
    byte_x({DEV, 1'b0}, 1'b1, r, a);
    byte_x(p, 1'b1, r, a);
    start();
    byte_x({DEV, 1'b1}, 1'b1, r, a);
    byte_x(8'hFF, 1'b0, d[15:8], a);
    byte_x(8'hFF, 1'b1, d[7:0], a);
    stop();
  endtask : rd
  task automatic bus_low();
    scl_o = 1'b0;
    #(2 * t);
    sda_pull_o = 1'b1;
  endtask : bus_low
  task automatic bus_up();
    scl_o = 1'b1;
    #(4 * t);
    sda_pull_o = 1'b0;
    #(4 * t);
  endtask : bus_up
endmodule : bg_host_model

// >>> verif/battery_gauge_host_control_bench.sv
// Purpose: self-checking bench of the gauge control block
// Assumes: short timing parameters, host model on the bus
// Notes: bit 6 of the setup register is not compared
`timescale 1ns/1ns
module battery_gauge_host_control_bench;
  localparam logic [15:0] REV = 16'h00A5; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic qs_pin = 1'b0;
  logic soc_vld = 1'b0;
  logic [15:0] soc_in = 16'h0000;
  logic [11:0] adc = 12'h000;
  logic sda_oe, alert_n, run, rstrt, scl, pull, ok;
  logic [15:0] d;
  logic [7:0] pct;
  logic [4:0] thr;
  wire sda;
  int mismatches, comparisons, n_rst, n0, setup_m, rnd;
  assign sda = ~(pull | sda_oe);
  always #25 clk = ~clk;
  always @(posedge clk) if (rst_n && rstrt === 1'b1) n_rst++;
  bg_gauge #(.REVISION(REV), .FIRST_AVG_CYC(50), .AVG_CYC(200), .BUS_SLEEP_CYC(100)) i_dut (
    .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .restart_pin_i(qs_pin), .low_charge_alert_n_o(alert_n), .adc_avg_i(adc),
    .soc_new_i(soc_in), .soc_valid_i(soc_vld), .gauge_run_o(run),
    .gauge_restart_o(rstrt), .first_estimate_o()
  );
  bg_host_model i_host (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input int exp, input logic [15:0] m,
                        input string s);
    logic [15:0] got;
    i_host.rd(a, got);
    chk(got & m, 16'(exp) & m, s);
  endtask : rd_chk
  task automatic soc(input logic [7:0] p);
    @(negedge clk);
    soc_in = {p, 8'h00};
    soc_vld = 1'b1;
    @(negedge clk);
    soc_vld = 1'b0;
    repeat (4) @(negedge clk);
  endtask : soc
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    #4_000_000;
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    rnd = $urandom(65634);
    adc = 12'($urandom);
    thr = 5'($urandom);
    pct = 8'h1F - 8'(thr);
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(alert_n, 1'b1, "alert idle");
    rd_chk(8'h0C, 'h971C, 16'hFFBF, "setup reset");
    rd_chk(8'h08, REV, 16'hFFFF, "revision");
    rd_chk(8'h02, adc * 16, 16'hFFFF, "first voltage");
    adc = 12'($urandom);
    repeat (220) @(negedge clk);
    rd_chk(8'h02, adc * 16, 16'hFFFF, "next voltage");
    $display("test voltage done");
    setup_m = 'h9700 | thr;
    i_host.wr(8'h0C, 16'(setup_m), 2, ok);
    chk(ok, 1'b1, "setup ack");
    rd_chk(8'h0C, setup_m, 16'hFFBF, "setup rw");
    i_host.wr(8'h04, 16'($urandom), 2, ok);
    rd_chk(8'h04, 0, 16'hFFFF, "charge read-only");
    i_host.wr(8'h20, 16'($urandom), 2, ok);
    i_host.rd(8'h20, d);
    i_host.t = 100;
    i_host.wr(8'h0C, 16'h0000, 1, ok);
    i_host.t = 50;
    rd_chk(8'h0C, setup_m, 16'hFFBF, "short write");
    $display("test registers done");
    soc(8'h20 - 8'(thr));
    chk(alert_n, 1'b1, "at threshold");
    soc(pct);
    chk(alert_n, 1'b0, "below threshold");
    setup_m = setup_m | 'h20;
    rd_chk(8'h0C, setup_m, 16'hFFBF, "alert flag");
    rd_chk(8'h04, pct * 256, 16'hFFFF, "charge level");
    i_host.wr(8'h0C, 16'(setup_m | 'h80), 2, ok);
    chk(run, 1'b0, "sleep bit");
    repeat (300) @(negedge clk);
    chk(alert_n, 1'b0, "alert in sleep");
    chk(run, 1'b0, "still asleep");
    i_host.wr(8'h0C, 16'(setup_m), 2, ok);
    chk(run, 1'b1, "sleep bit cleared");
    setup_m = setup_m & 'hFFDF;
    i_host.wr(8'h0C, 16'(setup_m), 2, ok);
    chk(alert_n, 1'b1, "flag cleared");
    soc(pct);
    chk(alert_n, 1'b1, "no rearm");
    soc(8'h21 - 8'(thr));
    soc(pct);
    chk(alert_n, 1'b0, "rearmed");
    setup_m = setup_m | 'h20;
    $display("test alert done");
    i_host.bus_low();
    repeat (120) @(negedge clk);
    chk(run, 1'b0, "bus sleep");
    i_host.bus_up();
    chk(run, 1'b1, "bus wake");
    rd_chk(8'h0C, setup_m, 16'hFFBF, "state kept");
    rd_chk(8'h04, pct * 256, 16'hFFFF, "charge kept");
    $display("test bus sleep done");
    setup_m = setup_m & 'hFFDF;
    i_host.wr(8'h0C, 16'(setup_m), 2, ok);
    n0 = n_rst;
    i_host.wr(8'h06, 16'h4000, 2, ok);
    chk(16'(n_rst), 16'(n0 + 1), "command quick-start");
    rd_chk(8'h04, 0, 16'hFFFF, "charge restarted");
    qs_pin = 1'b1;
    repeat (8) @(negedge clk);
    qs_pin = 1'b0;
    chk(16'(n_rst), 16'(n0 + 2), "pin quick-start");
    $display("test quick-start done");
    i_host.wr(8'hFE, 16'h0054, 2, ok);
    chk(ok, 1'b0, "no acknowledge");
    rd_chk(8'h0C, 'h971C, 16'hFFBF, "full reset");
    soc(8'h03);
    chk(alert_n, 1'b0, "alert from power-up");
    $display("test full reset done");
    stop_test();
  end
endmodule : battery_gauge_host_control_bench
